/* shared/sed_defines.vh */
`ifndef SED_DEFINES_VH
`define SED_DEFINES_VH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define SED_ADDR_W      7
`define SED_PAGE_W      3
`define SED_PAGE_BYTES  8

// ----------------------------------------
// device address byte
// ----------------------------------------
`define SED_DEV_TYPE    4'h6  // type code value is arbitrary
`define SED_DIR_READ    1'b1

// ----------------------------------------
// timing
// ----------------------------------------
`define SED_CLK_MHZ     125
`define SED_TPROG_US    5000
`define SED_BITS_BYTE   4'h8
`define SED_BIT_ACK     4'h9

`endif

/* hdl/sed_sync.v */
`timescale 1ns/1ps
`default_nettype none

// two flip-flop synchroniser for pin inputs
module sed_sync #(
  parameter WIDTH = 3
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             srst,
  // asynchronous in, synchronous out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  // ----------------------------------------
  // two stages, first read only by second
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      meta_r   <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // sed_sync

`default_nettype wire

/* hdl/sed_eeprom.v */
// Overview of operation
// - master nack on a sent byte stops sending; wait for stop before standby.
// - stop after a write starts self-timed programming of received data.
// - further data bytes after the first turn a byte write into a page write.
// - page write increments only low three address bits; upper four held.
// - more than eight page bytes wrap in the page, overwriting earlier ones.
// - address counter holds last read word plus one, or last written word, for current reads.
// - after reading n, next read returns n+1 and advances again.
// - after writing n last, next read starts at n.
// - current read with nack then stop delivers one byte, then releases data.
// - read-direction address is acked, then eight data bits shifted out.
// - random read with nack and stop stops transmitting.
// - sequential read advances the counter on each master ack.
// - read counter increments fully and wraps from top to location zero.
// - sequential reading continues from both current and random reads.
// - address byte type field must match; otherwise no acknowledge.
// - in a write, each further received byte is acknowledged.
// - writes blocked while enable low; lowering it never aborts programming.
`timescale 1ns/1ps
`default_nettype none
`include "sed_defines.vh"

module sed_eeprom #(
  parameter PROG_CYCLES = `SED_TPROG_US * `SED_CLK_MHZ
) (
  // clock and reset
  input  wire ref_clk,
  input  wire srst,
  // two-wire bus pins
  input  wire scl,
  input  wire sda_in,
  output reg  sda_out,
  output reg  sda_oe,
  // write protect pin
  input  wire write_enable_input,
  // status
  output reg  prog_busy
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE  = 3'd0;
  localparam ST_DEV   = 3'd1;
  localparam ST_WORD  = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_READ  = 3'd4;
  localparam ST_WAIT  = 3'd5;

  // full-counter increment with wrap after 127
  function [`SED_ADDR_W-1:0] next_addr;
    input [`SED_ADDR_W-1:0] a;
    begin
      next_addr = a + 7'h01;
    end
  endfunction

  // ----------------------------------------
  // pin sampling and bus events
  // ----------------------------------------
  wire [2:0] pins_s;
  reg        scl_d_r;
  reg        sda_d_r;

  sed_sync #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in ({scl, sda_in, write_enable_input}),
    .sync_out (pins_s)
  );

  wire scl_s    = pins_s[2];
  wire sda_s    = pins_s[1];
  wire wen_s    = pins_s[0];
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  always @(posedge ref_clk) begin
    if (srst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [7:0]             mem_r  [0:(1<<`SED_ADDR_W)-1];
  reg [7:0]             pbuf_r [0:`SED_PAGE_BYTES-1];
  reg [`SED_PAGE_BYTES-1:0] pvalid_r;
  reg [`SED_ADDR_W-`SED_PAGE_W-1:0] page_r;

  // ----------------------------------------
  // protocol state
  // ----------------------------------------
  reg [2:0]             state_r;
  reg [3:0]             cnt_r;
  reg                   ackph_r;
  reg [7:0]             sh_r;
  reg [7:0]             tx_r;
  reg [`SED_ADDR_W-1:0] addr_r;
  reg [`SED_ADDR_W-1:0] wr_last_r;
  reg                   wr_pend_r;
  reg                   prog_go_r;
  reg [19:0]            prog_cnt_r;
  integer               i;

  wire [`SED_ADDR_W-1:0] addr_inc = next_addr(addr_r);
  wire                   type_ok  = (sh_r[7:4] == `SED_DEV_TYPE);

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      state_r   <= ST_IDLE;
      cnt_r     <= 4'h0;
      ackph_r   <= 1'b0;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      addr_r    <= 7'h00;
      wr_last_r <= 7'h00;
      wr_pend_r <= 1'b0;
      prog_go_r <= 1'b0;
      pvalid_r  <= 8'h00;
      page_r    <= 4'h0;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
    end else begin
      prog_go_r <= 1'b0;
      if (stop_ev) begin
        // stop ends any command and releases the line
        state_r <= ST_IDLE;
        sda_oe  <= 1'b0;
        ackph_r <= 1'b0;
        if (state_r == ST_WDATA && wr_pend_r) begin
          addr_r    <= wr_last_r;
          wr_pend_r <= 1'b0;
          if (wen_s)
            prog_go_r <= 1'b1;
          else
            pvalid_r  <= 8'h00;
        end
      end else if (start_ev) begin
        state_r   <= ST_DEV;
        cnt_r     <= 4'h0;
        ackph_r   <= 1'b0;
        sda_oe    <= 1'b0;
        wr_pend_r <= 1'b0;
      end else begin
        case (state_r)
          ST_DEV, ST_WORD, ST_WDATA: begin
            if (scl_rise && cnt_r < `SED_BITS_BYTE) begin
              sh_r  <= {sh_r[6:0], sda_s};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == `SED_BITS_BYTE && !ackph_r) begin
              ackph_r <= 1'b1;
              case (state_r)
                ST_DEV: begin
                  if (type_ok && !prog_busy) begin
                    sda_oe <= 1'b1;
                    if (sh_r[0] == `SED_DIR_READ) begin
                      state_r <= ST_READ;
                      cnt_r   <= 4'h0;
                      tx_r    <= mem_r[addr_r];
                      addr_r  <= addr_inc;
                    end
                  end else begin
                    state_r <= ST_WAIT;
                  end
                end
                ST_WORD: begin
                  sda_oe   <= 1'b1;
                  addr_r   <= sh_r[6:0];
                  page_r   <= sh_r[6:3];
                  pvalid_r <= 8'h00;
                end
                default: begin
                  sda_oe <= 1'b1;
                  pbuf_r[addr_r[2:0]]   <= sh_r;
                  pvalid_r[addr_r[2:0]] <= 1'b1;
                  wr_last_r <= addr_r;
                  wr_pend_r <= 1'b1;
                  addr_r <= {addr_r[6:3], addr_r[2:0] + 3'h1};
                end
              endcase
            end else if (scl_fall && ackph_r) begin
              // end of the ack bit
              ackph_r <= 1'b0;
              cnt_r   <= 4'h0;
              sda_oe  <= 1'b0;
              if (state_r == ST_DEV)
                state_r <= ST_WORD;
              else if (state_r == ST_WORD)
                state_r <= ST_WDATA;
            end
          end
          ST_READ: begin
            if (scl_fall && cnt_r < `SED_BITS_BYTE) begin
              ackph_r <= 1'b0;
              sda_oe  <= ~tx_r[7];
              tx_r    <= {tx_r[6:0], 1'b0};
              cnt_r   <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == `SED_BITS_BYTE) begin
              sda_oe <= 1'b0;                     // release for master ack
              cnt_r  <= `SED_BIT_ACK;
            end else if (scl_rise && cnt_r == `SED_BIT_ACK) begin
              if (!sda_s) begin
                cnt_r  <= 4'h0;
                tx_r   <= mem_r[addr_r];
                addr_r <= addr_inc;
              end else begin
                state_r <= ST_WAIT;
              end
            end
          end
          ST_WAIT: begin
            // drive nothing until stop or start
            if (scl_fall)
              sda_oe <= 1'b0;
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
      if (prog_busy && prog_cnt_r == 20'h00001)
        pvalid_r <= 8'h00;
    end
  end

  // ----------------------------------------
  // self-timed programming
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (srst) begin
      prog_busy  <= 1'b0;
      prog_cnt_r <= 20'h00000;
    end else if (prog_go_r) begin
      prog_busy  <= 1'b1;
      prog_cnt_r <= PROG_CYCLES[19:0];
    end else if (prog_busy) begin
      // enable pin is not watched here, so it cannot abort
      prog_cnt_r <= prog_cnt_r - 20'h00001;
      if (prog_cnt_r == 20'h00001)
        prog_busy <= 1'b0;
    end
  end

  // commit the page buffer into the array at the end
  always @(posedge ref_clk) begin
    if (prog_busy && prog_cnt_r == 20'h00001) begin
      for (i = 0; i < `SED_PAGE_BYTES; i = i + 1) begin
        if (pvalid_r[i])
          mem_r[{page_r, i[2:0]}] <= pbuf_r[i];
      end
    end
  end

endmodule // sed_eeprom

`default_nettype wire

/* sim/sed_eeprom_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sed_eeprom_checker #(
  parameter PROG_CYCLES = 50
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // pins
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_enable_input,
  input wire logic prog_busy
);
  logic [3:0] hi_r;
  int         busy_r;
  // scl high run and busy run lengths
  always @(posedge ref_clk) begin
    if (srst || !scl) hi_r <= 4'h0;
    else if (hi_r != 4'hf) hi_r <= hi_r + 4'h1;
    if (srst || !prog_busy) busy_r <= 0;
    else busy_r <= busy_r + 1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_out_low: assert property (sda_out == 1'h0)
    else $error("sda_out not low");
  a_reset_quiet: assert property ($fell(srst) |-> !sda_oe && !prog_busy)
    else $error("busy or drive after reset");
  a_hold_high: assert property (hi_r >= 4'h3 |-> $stable(sda_oe))
    else $error("sda changed while scl high");
  a_busy_min: assert property ($fell(prog_busy) |-> busy_r >= PROG_CYCLES - 4)
    else $error("programming cut short");
  a_busy_max: assert property (busy_r <= PROG_CYCLES + 4)
    else $error("programming too long");
  a_busy_stop: assert property ($rose(prog_busy) |->
    scl && sda_in && $past(write_enable_input, 8))
    else $error("programming without stop or enable");
  a_busy_quiet: assert property (prog_busy |-> !sda_oe)
    else $error("answer during programming");
  a_stop_release: assert property (scl && $past(scl) && $rose(sda_in) |->
    ##[1:6] !sda_oe)
    else $error("sda held after stop");
  // main scenarios
  c_prog: cover property ($rose(prog_busy));
  c_drive: cover property (sda_oe && scl);
  c_we_low: cover property ($fell(prog_busy) && !write_enable_input);
endmodule // sed_eeprom_checker
bind sed_eeprom sed_eeprom_checker #(.PROG_CYCLES(PROG_CYCLES)) sed_eeprom_checker_inst (
  .ref_clk(ref_clk), .srst(srst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_enable_input(write_enable_input), .prog_busy(prog_busy));
`default_nettype wire

/* sim/sed_i2c_master.sv */
`timescale 1ns/1ps
`default_nettype none
module sed_i2c_master (
  // clock
  input  wire logic ref_clk,
  // bus
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_drv
);
  // idle bus released high, scl still
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  // wait cycles, change just after edge
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // start or repeated start
  task automatic start;
    sda_drv = 1'h1;
    w(4); // scl low until the device has dropped its ack
    scl = 1'h1;
    w(4);
    sda_drv = 1'h0;
    w(4);
    scl = 1'h0;
  endtask
  // stop from scl low
  task automatic stop;
    w(2);
    sda_drv = 1'h0;
    w(2);
    scl = 1'h1;
    w(4);
    sda_drv = 1'h1;
    w(4);
  endtask
  // one bit, 64 ns period, sampled at end of high
  task automatic bit1(input logic b, output logic r);
    w(2);
    sda_drv = b;
    w(2);
    scl = 1'h1;
    w(4);
    r = sda;
    scl = 1'h0;
  endtask
  // byte msb first, ninth bit is ack
  task automatic io(input [7:0] d, input logic a, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) bit1(d[i], q[i]);
    bit1(a, r);
  endtask
endmodule // sed_i2c_master
`default_nettype wire

/* sim/tb_serial_eeprom_bidir_commands.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_bidir_commands;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic we = 1'h1;
  wire  scl, sda_drv, sda_oe, sda_out, busy;
  wire  sda = sda_drv & ~sda_oe;
  int   checks = 0;
  int   miscompares = 0;
  // address and data of each row
  logic [14:0] rows [4] = '{15'h7fc3, 15'h005a, 15'h4081, 15'h1f3c};
  sed_eeprom #(.PROG_CYCLES(200)) sed_eeprom_inst (.ref_clk(ref_clk), .srst(srst),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_enable_input(we), .prog_busy(busy));
  sed_i2c_master sed_i2c_master_inst (.ref_clk(ref_clk), .sda(sda), .scl(scl),
    .sda_drv(sda_drv));
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input [7:0] e, input [7:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic snd(input [7:0] b, input logic e);
    logic [7:0] q;
    logic r;
    sed_i2c_master_inst.io(b, 1'h1, q, r);
    chk("ack", {7'h0, e}, {7'h0, ~r});
  endtask
  // read a byte; last one is nacked, then sda must be free
  task automatic rcv(input [7:0] e, input logic l);
    logic [7:0] q;
    logic r;
    sed_i2c_master_inst.io(8'hff, l, q, r);
    chk("data", e, q);
    if (l) begin
      sed_i2c_master_inst.w(6);
      chk("release", 8'h1, {7'h0, sda});
    end
  endtask
  // bounded wait for programming to end
  task automatic idle;
    int n;
    sed_i2c_master_inst.w(8);
    for (n = 0; n < 400 && busy !== 1'h0; n++) sed_i2c_master_inst.w(1);
    if (n == 400) begin
      miscompares++;
      results();
    end
  endtask
  task automatic wr(input [6:0] a, input [7:0] d);
    sed_i2c_master_inst.start();
    snd(8'h60, 1'h1);
    snd({1'h0, a}, 1'h1);
    snd(d, 1'h1);
    sed_i2c_master_inst.stop();
    idle();
  endtask
  // set address, then repeated start for read
  task automatic at(input [6:0] a);
    sed_i2c_master_inst.start();
    snd(8'h60, 1'h1);
    snd({1'h0, a}, 1'h1);
    sed_i2c_master_inst.start();
    snd(8'h61, 1'h1);
  endtask
  initial forever #4 ref_clk = ~ref_clk;
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 srst = 1'h0;
    chk("reset", 8'h0, {6'h0, busy, sda_oe});
    sed_i2c_master_inst.w(4);
    for (int i = 0; i < 4; i++) begin
      wr(rows[i][14:8], rows[i][7:0]);
      at(rows[i][14:8]);
      rcv(rows[i][7:0], 1'h1);
      sed_i2c_master_inst.stop();
    end
    at(7'h7f);
    rcv(8'hc3, 1'h0);
    rcv(8'h5a, 1'h1);
    sed_i2c_master_inst.stop();
    // ten bytes into page 38..3f from offset 5
    sed_i2c_master_inst.start();
    snd(8'h60, 1'h1);
    snd(8'h3d, 1'h1);
    for (int k = 0; k < 10; k++) snd(8'(8'h10 + k), 1'h1);
    sed_i2c_master_inst.stop();
    sed_i2c_master_inst.start();
    snd(8'h60, 1'h0);
    sed_i2c_master_inst.stop();
    we = 1'h0;
    idle();
    we = 1'h1;
    sed_i2c_master_inst.start();
    snd(8'h61, 1'h1);
    rcv(8'h19, 1'h0);
    rcv(8'h12, 1'h0);
    rcv(8'h81, 1'h1);
    sed_i2c_master_inst.stop();
    at(7'h38);
    rcv(8'h13, 1'h1);
    sed_i2c_master_inst.stop();
    we = 1'h0;
    wr(7'h40, 8'hee);
    we = 1'h1;
    at(7'h40);
    rcv(8'h81, 1'h1);
    sed_i2c_master_inst.stop();
    sed_i2c_master_inst.start();
    snd(8'h50, 1'h0);
    sed_i2c_master_inst.stop();
    sed_i2c_master_inst.start();
    snd(8'h6e, 1'h1);
    sed_i2c_master_inst.stop();
    results();
  end
endmodule // tb_serial_eeprom_bidir_commands
`default_nettype wire
